// ==== dtwbsp_defines.svh ====
// shared widths, codes and link timing counts for the ddr burst sram port
`ifndef DTWBSP_DEFINES_SVH
`define DTWBSP_DEFINES_SVH

// ------------------------------------------------------------------
// array shape
// ------------------------------------------------------------------
`define DTWBSP_WORD_W 18
`define DTWBSP_ADDR_W 21
`define DTWBSP_LANES 2
// word widths at or above this load the burst start from the address lsb
`define DTWBSP_WIDE_MIN_W 18

// ------------------------------------------------------------------
// controller schedule, in clk ticks counted from the issue tick
// ------------------------------------------------------------------
`define DTWBSP_T_STROBE_OFF 5'h04
`define DTWBSP_T_WD0 5'h04
`define DTWBSP_T_WD1 5'h07
`define DTWBSP_T_WOFF 5'h09
`define DTWBSP_T_RD0_OFF 5'h09
`define DTWBSP_T_DLL_EXTRA 5'h02
`define DTWBSP_T_WORD_GAP 5'h02
`define DTWBSP_T_NEXT_WR 5'h08
`define DTWBSP_T_NEXT_RD 5'h10
`define DTWBSP_T_SAT 5'h1f

`endif

// ==== dtwbsp_pkg.sv ====
// types shared by both ends of the ddr burst sram port
package dtwbsp_pkg;
    // operation carried by one address slot
    typedef enum logic [1:0] {
        DTWBSP_OP_NONE,
        DTWBSP_OP_READ,
        DTWBSP_OP_WRITE
    } dtwbsp_op_type;
endpackage : dtwbsp_pkg

// ==== dtwbsp_link_if.sv ====
// link wires between the memory controller and the burst sram
`timescale 1ns/1ps
`default_nettype none
`include "dtwbsp_defines.svh"
interface dtwbsp_link_if #(
    parameter int ADDR_W = `DTWBSP_ADDR_W,
    parameter int WORD_W = `DTWBSP_WORD_W,
    parameter int LANES = `DTWBSP_LANES
);
    logic k;
    logic k_n;
    logic load_strobe_n;
    logic read_write_sel;
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0] byte_write_select_n;
    logic dll_disable_pin;
    logic [WORD_W-1:0] ctl_dq_out;
    logic ctl_dq_oe;
    logic [WORD_W-1:0] dev_dq_out;
    logic dev_dq_oe;
    logic [WORD_W-1:0] dq;
    logic echo_clk_out;
    logic echo_clk_out_n;

    // shared data pins; an idle bus reads as zero
    assign dq = dev_dq_oe ? dev_dq_out : (ctl_dq_oe ? ctl_dq_out : '0);

    modport dev (
        input k, k_n, load_strobe_n, read_write_sel, addr,
        input byte_write_select_n, dll_disable_pin, dq,
        output dev_dq_out, dev_dq_oe, echo_clk_out, echo_clk_out_n
    );
    modport ctl (
        output k, k_n, load_strobe_n, read_write_sel, addr,
        output byte_write_select_n, dll_disable_pin, ctl_dq_out, ctl_dq_oe,
        input dq, echo_clk_out, echo_clk_out_n
    );
endinterface : dtwbsp_link_if
`default_nettype wire

// ==== dtwbsp_half_stage.sv ====
// complement-clock stage: second write word capture and half-cycle launch
`timescale 1ns/1ps
`default_nettype none
`include "dtwbsp_defines.svh"
module dtwbsp_half_stage import dtwbsp_pkg::*; #(
    parameter int WORD_W = `DTWBSP_WORD_W,
    parameter int LANES = `DTWBSP_LANES
) (
    input wire logic k_n_clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic [WORD_W-1:0] dq_in,
    input wire logic [LANES-1:0] be_n_in,
    input wire logic [WORD_W-1:0] launch_word,
    input wire logic launch_oe,
    output logic [WORD_W-1:0] cap_word,
    output logic [LANES-1:0] cap_be_n,
    output logic [WORD_W-1:0] q,
    output logic q_oe
);
    typedef struct packed {
        logic [WORD_W-1:0] cap;
        logic [LANES-1:0] be_n;
        logic [WORD_W-1:0] q;
        logic q_oe;
    } dtwbsp_half_state_type;

    dtwbsp_half_state_type s_r;
    dtwbsp_half_state_type s_nxt;

    // every complement edge takes the second word and launches its word
    always_comb begin
        s_nxt = s_r;
        s_nxt.cap = dq_in;           // see R2
        s_nxt.be_n = be_n_in;
        s_nxt.q = launch_word;       // see R3
        s_nxt.q_oe = launch_oe;
    end

    always_ff @(posedge k_n_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_r <= '0;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign cap_word = s_r.cap;
    assign cap_be_n = s_r.be_n;
    assign q = s_r.q;
    assign q_oe = s_r.q_oe;
endmodule : dtwbsp_half_stage
`default_nettype wire

// ==== dtwbsp_device.sv ====
// sram end of the link: input registers, burst array, ddr read launch
//
// Functional notes
// R1: one address every second k rising edge; the controller here spaces reads four k cycles apart
// R2: write words taken on k and k_n
// R3: read words launched on k/k_n edges
// R4: two words per address, burst order
// R5: narrow widths start burst at word zero
// R6: wide widths start burst at address lsb
// R7: dll on: first word 1.5 cycles later
// R8: dll off: first word one cycle later
// R9: all inputs registered on k first; the second write word and its lane selects are registered on k_n instead
// R10: array write completes internally, self-timed
// R11: echo clocks aligned with read data
// R12: data pins shared, controller releases them
// R13: controller starts ops with load strobe low
`timescale 1ns/1ps
`default_nettype none
`include "dtwbsp_defines.svh"
module dtwbsp_device import dtwbsp_pkg::*; #(
    parameter int ADDR_W = `DTWBSP_ADDR_W,
    parameter int WORD_W = `DTWBSP_WORD_W,
    parameter int LANES = `DTWBSP_LANES
) (
    input wire logic rst_b,
    input wire logic ce,
    dtwbsp_link_if.dev link,
    output logic dll_off_status,
    output logic write_commit
);
    // ------------------------------------------------------------------
    // shape of the array
    // ------------------------------------------------------------------
    localparam bit WIDE = (WORD_W >= `DTWBSP_WIDE_MIN_W);
    localparam int LANE_W = WORD_W / LANES;
    localparam int IDX_W = ADDR_W + 1;

    typedef struct packed {
        logic dll_s1;                 // first sync flop of the mode pin
        logic dll_s2;                 // high: dll switched off
        dtwbsp_op_type cmd;           // op taken at the last k edge
        logic [ADDR_W-1:0] addr;
        logic [IDX_W-1:0] widx0;
        logic [IDX_W-1:0] widx1;
        logic wpend;
        logic [WORD_W-1:0] wd0;
        logic [LANES-1:0] wbe0_n;
        logic [WORD_W-1:0] rd1;
        logic late;                   // second read word waits one k edge
        logic [WORD_W-1:0] q;
        logic q_oe;
        logic [WORD_W-1:0] hq;        // word handed to the k_n stage
        logic hq_oe;
    } dtwbsp_dev_state_type;

    dtwbsp_dev_state_type s_r;
    dtwbsp_dev_state_type s_nxt;

    logic [WORD_W-1:0] mem [0:(1<<IDX_W)-1];
    logic [WORD_W-1:0] half_cap;
    logic [LANES-1:0] half_be_n;
    logic [WORD_W-1:0] half_q;
    logic half_q_oe;
    logic burst_start;
    logic [WORD_W-1:0] rd0;
    logic [WORD_W-1:0] rd1;
    logic [WORD_W-1:0] old0;
    logic [WORD_W-1:0] old1;
    logic [WORD_W-1:0] merged0;
    logic [WORD_W-1:0] merged1;

    // ------------------------------------------------------------------
    // burst addressing
    // ------------------------------------------------------------------
    // one location holds two words; the 1-bit counter picks the word
    function automatic logic [IDX_W-1:0] word_index(
        input logic [ADDR_W-1:0] a,
        input logic cnt
    );
        logic [IDX_W-1:0] idx;
        if (WIDE) begin
            idx = {1'b0, a[ADDR_W-1:1], cnt};   // see R4
        end else begin
            idx = {a, cnt};                     // see R4
        end
        return idx;
    endfunction : word_index

    // wide parts load the lsb, narrow parts always count from zero
    assign burst_start = WIDE ? s_r.addr[0] : 1'b0;  // see R5 see R6

    // array read for the op latched last edge, in burst order
    assign rd0 = mem[word_index(s_r.addr, burst_start)];
    assign rd1 = mem[word_index(s_r.addr, ~burst_start)];

    // ------------------------------------------------------------------
    // byte lane merge for writes
    // ------------------------------------------------------------------
    assign old0 = mem[s_r.widx0];
    assign old1 = mem[s_r.widx1];

    // a lane whose select is high keeps its stored bits
    for (genvar l = 0; l < LANES; l++) begin : g_lane
        assign merged0[l*LANE_W +: LANE_W] = s_r.wbe0_n[l] ?
            old0[l*LANE_W +: LANE_W] : s_r.wd0[l*LANE_W +: LANE_W];
        assign merged1[l*LANE_W +: LANE_W] = half_be_n[l] ?
            old1[l*LANE_W +: LANE_W] : half_cap[l*LANE_W +: LANE_W];
    end

    // ------------------------------------------------------------------
    // next state on the k edge
    // ------------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        // the mode pin is a slow level; two flops before anyone looks
        s_nxt.dll_s1 = link.dll_disable_pin;
        s_nxt.dll_s2 = s_r.dll_s1;
        // input registers: strobe, direction and address
        if (!link.load_strobe_n) begin                           // see R9
            s_nxt.cmd = link.read_write_sel ? DTWBSP_OP_READ : DTWBSP_OP_WRITE;
            s_nxt.addr = link.addr;                              // see R1
        end else begin
            s_nxt.cmd = DTWBSP_OP_NONE;
        end
        // launch flags last one edge unless refreshed
        s_nxt.q_oe = 1'b0;
        s_nxt.hq_oe = 1'b0;
        s_nxt.late = 1'b0;
        s_nxt.wpend = 1'b0;
        unique case (s_r.cmd)
            DTWBSP_OP_WRITE: begin
                // first word on this k edge, second on the next k_n edge
                s_nxt.wd0 = link.dq;                             // see R2
                s_nxt.wbe0_n = link.byte_write_select_n;
                s_nxt.widx0 = word_index(s_r.addr, burst_start);
                s_nxt.widx1 = word_index(s_r.addr, ~burst_start);
                s_nxt.wpend = 1'b1;                              // see R10
            end
            DTWBSP_OP_READ: begin
                if (s_r.dll_s2) begin
                    // dll off: word 0 now, word 1 half a cycle later
                    s_nxt.q = rd0;                               // see R8
                    s_nxt.q_oe = 1'b1;
                    s_nxt.hq = rd1;
                    s_nxt.hq_oe = 1'b1;
                end else begin
                    // dll on: word 0 on the k_n edge, word 1 on next k
                    s_nxt.hq = rd0;                              // see R7
                    s_nxt.hq_oe = 1'b1;
                    s_nxt.rd1 = rd1;
                    s_nxt.late = 1'b1;
                end
            end
            DTWBSP_OP_NONE: begin
            end
        endcase
        if (s_r.late) begin
            s_nxt.q = s_r.rd1;                                   // see R7
            s_nxt.q_oe = 1'b1;
        end
    end

    always_ff @(posedge link.k or negedge rst_b) begin
        if (!rst_b) begin
            s_r <= '0;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    // self-timed commit one k edge after the second word arrived
    always_ff @(posedge link.k) begin
        if (ce && s_r.wpend) begin
            mem[s_r.widx0] <= merged0;                           // see R10
            mem[s_r.widx1] <= merged1;
        end
    end

    // ------------------------------------------------------------------
    // complement-clock stage
    // ------------------------------------------------------------------
    dtwbsp_half_stage #(
        .WORD_W(WORD_W),
        .LANES(LANES)
    ) u_half (
        .k_n_clk(link.k_n),
        .rst_b(rst_b),
        .ce(ce),
        .dq_in(link.dq),
        .be_n_in(link.byte_write_select_n),
        .launch_word(s_r.hq),
        .launch_oe(s_r.hq_oe),
        .cap_word(half_cap),
        .cap_be_n(half_be_n),
        .q(half_q),
        .q_oe(half_q_oe)
    );

    // ------------------------------------------------------------------
    // pins
    // ------------------------------------------------------------------
    // no separate output clock pair here, so the k pair launches data;
    // the k-high half shows the k register, the other half the k_n one
    assign link.dev_dq_out = link.k ? s_r.q : half_q;           // see R3
    assign link.dev_dq_oe = link.k ? s_r.q_oe : half_q_oe;      // see R12
    // echo clocks follow the launch clocks, so data edges match them
    assign link.echo_clk_out = link.k;                          // see R11
    assign link.echo_clk_out_n = link.k_n;
    assign dll_off_status = s_r.dll_s2;
    assign write_commit = s_r.wpend;
endmodule : dtwbsp_device
`default_nettype wire

// ==== dtwbsp_ctrl.sv ====
// controller end: makes the link clock, issues bursts, captures reads
`timescale 1ns/1ps
`default_nettype none
`include "dtwbsp_defines.svh"
module dtwbsp_ctrl import dtwbsp_pkg::*; #(
    parameter int ADDR_W = `DTWBSP_ADDR_W,
    parameter int WORD_W = `DTWBSP_WORD_W,
    parameter int LANES = `DTWBSP_LANES
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [WORD_W-1:0] req_wdata0,
    input wire logic [WORD_W-1:0] req_wdata1,
    input wire logic [LANES-1:0] req_be_n0,
    input wire logic [LANES-1:0] req_be_n1,
    input wire logic dll_off,
    output logic req_ready,
    output logic rsp_valid,
    output logic [WORD_W-1:0] rsp_data0,
    output logic [WORD_W-1:0] rsp_data1,
    dtwbsp_link_if.ctl link
);
    typedef struct packed {
        logic [1:0] phase;
        logic k;
        logic k_n;
        dtwbsp_op_type op;
        logic [4:0] otick;
        logic dll_pin;
        logic dll_op;                 // mode of the op in flight
        logic strobe_n;
        logic rw;
        logic [ADDR_W-1:0] addr;
        logic [WORD_W-1:0] wd0;
        logic [WORD_W-1:0] wd1;
        logic [LANES-1:0] be0_n;
        logic [LANES-1:0] be1_n;
        logic [WORD_W-1:0] dq;
        logic dq_oe;
        logic drv_end;                // write drive ends at the next tick
        logic [LANES-1:0] lane_sel_n;
        logic [WORD_W-1:0] sync1;
        logic [WORD_W-1:0] sync2;
        logic [WORD_W-1:0] rd0;
        logic rsp_v;
        logic [WORD_W-1:0] rsp0;
        logic [WORD_W-1:0] rsp1;
    } dtwbsp_ctl_state_type;

    dtwbsp_ctl_state_type s_r;
    dtwbsp_ctl_state_type s_nxt;
    logic free;
    logic [4:0] rd0_tick;

    // a new op may go once the previous one no longer needs the pins
    always_comb begin
        unique case (s_r.op)
            DTWBSP_OP_NONE: free = 1'b1;
            DTWBSP_OP_WRITE: free = (s_r.otick + 5'h01) >= `DTWBSP_T_NEXT_WR;
            DTWBSP_OP_READ: free = (s_r.otick + 5'h01) >= `DTWBSP_T_NEXT_RD;
            default: free = 1'b1;
        endcase
    end
    // slots fall only on the tick before k falls; free spaces writes two k cycles apart, reads four
    assign req_ready = ce && free && (s_r.phase == 2'h1);        // see R1
    assign rd0_tick = `DTWBSP_T_RD0_OFF + (s_r.dll_op ? 5'h00 : `DTWBSP_T_DLL_EXTRA);

    always_comb begin
        s_nxt = s_r;
        s_nxt.rsp_v = 1'b0;
        s_nxt.dll_pin = dll_off;
        // divide by four: k rises at phase 0, k_n at phase 2
        s_nxt.phase = s_r.phase + 2'h1;
        if (s_nxt.phase == 2'h0) begin
            s_nxt.k = 1'b1;
            s_nxt.k_n = 1'b0;
        end else if (s_nxt.phase == 2'h2) begin
            s_nxt.k = 1'b0;
            s_nxt.k_n = 1'b1;
        end
        // read data crosses on two flops before use
        s_nxt.sync1 = link.dq;
        s_nxt.sync2 = s_r.sync1;
        if (s_r.otick != `DTWBSP_T_SAT) begin
            s_nxt.otick = s_r.otick + 5'h01;
        end
        if (req_ready && req_valid) begin
            s_nxt.op = req_write ? DTWBSP_OP_WRITE : DTWBSP_OP_READ;
            s_nxt.otick = 5'h00;
            s_nxt.strobe_n = 1'b0;                               // see R13
            s_nxt.rw = !req_write;
            s_nxt.addr = req_addr;
            s_nxt.wd0 = req_wdata0;
            s_nxt.wd1 = req_wdata1;
            s_nxt.be0_n = req_be_n0;
            s_nxt.be1_n = req_be_n1;
            s_nxt.dll_op = s_r.dll_pin;
        end else if (free) begin
            s_nxt.op = DTWBSP_OP_NONE;
        end
        // strobe high again once the k edge has taken it
        if (s_nxt.otick == `DTWBSP_T_STROBE_OFF) begin
            s_nxt.strobe_n = 1'b1;                               // see R13
        end
        if (s_r.op == DTWBSP_OP_WRITE) begin
            // word 0 is set half a k period before its k edge, word 1 a quarter period before its k_n edge
            if (s_nxt.otick == `DTWBSP_T_WD0) begin
                s_nxt.dq = s_r.wd0;                              // see R2
                s_nxt.lane_sel_n = s_r.be0_n;
                s_nxt.dq_oe = 1'b1;
            end else if (s_nxt.otick == `DTWBSP_T_WD1) begin
                s_nxt.dq = s_r.wd1;
                s_nxt.lane_sel_n = s_r.be1_n;
            end
        end
        // flagged from the old op's count, so a take on the free tick
        // cannot leave the pins driven into the next op
        s_nxt.drv_end = (s_r.op == DTWBSP_OP_WRITE) &&
            ((s_r.otick + 5'h02) == `DTWBSP_T_WOFF);
        if (s_r.drv_end) begin
            s_nxt.dq_oe = 1'b0;                                  // see R12
        end
        if (s_r.op == DTWBSP_OP_READ) begin
            // capture ticks follow the echo edges by the sync depth
            if (s_nxt.otick == rd0_tick) begin
                s_nxt.rd0 = s_r.sync2;                           // see R7 see R8 see R11
            end else if (s_nxt.otick == rd0_tick + `DTWBSP_T_WORD_GAP) begin
                s_nxt.rsp0 = s_r.rd0;
                s_nxt.rsp1 = s_r.sync2;
                s_nxt.rsp_v = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_r <= '0;
            s_r.k_n <= 1'b1;
            s_r.strobe_n <= 1'b1;
            s_r.rw <= 1'b1;
            s_r.lane_sel_n <= '1;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign link.k = s_r.k;
    assign link.k_n = s_r.k_n;
    assign link.load_strobe_n = s_r.strobe_n;
    assign link.read_write_sel = s_r.rw;
    assign link.addr = s_r.addr;
    assign link.byte_write_select_n = s_r.lane_sel_n;
    assign link.dll_disable_pin = s_r.dll_pin;
    assign link.ctl_dq_out = s_r.dq;
    assign link.ctl_dq_oe = s_r.dq_oe;
    assign rsp_valid = s_r.rsp_v;
    assign rsp_data0 = s_r.rsp0;
    assign rsp_data1 = s_r.rsp1;
endmodule : dtwbsp_ctrl
`default_nettype wire

// ==== dtwbsp_link_monitor.sv ====
// concurrent checks on the link wires between controller and burst sram
`timescale 1ns/1ps
`default_nettype none
module dtwbsp_link_monitor (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic k,
    input wire logic k_n,
    input wire logic load_strobe_n,
    input wire logic read_write_sel,
    input wire logic dll_disable_pin,
    input wire logic ctl_dq_oe,
    input wire logic dev_dq_oe,
    input wire logic echo_clk_out,
    input wire logic echo_clk_out_n
);
    // ------------------------------------------------------------------
    // link timing, counted in clk ticks from the strobe falling
    // ------------------------------------------------------------------
    // k is made from clk by the controller, so clk sees every k edge
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    // start of a read or a write slot
    sequence rd_start_s;
        $fell(load_strobe_n) && read_write_sel;
    endsequence
    sequence wr_start_s;
        $fell(load_strobe_n) && !read_write_sel;
    endsequence

    strobe_to_k_a: assert property ($fell(load_strobe_n) |-> !k ##2 $rose(k))
        else $error("address slot not latched on the next k rise");
    strobe_width_a: assert property ($fell(load_strobe_n) |-> !load_strobe_n[*4] ##1 load_strobe_n)
        else $error("load strobe not held for exactly one k cycle");
    k_pair_a: assert property (k_n != k)
        else $error("k and k_n are not complementary");
    echo_align_a: assert property ($rose(k) |-> ##[0:1] (echo_clk_out && !echo_clk_out_n))
        else $error("echo clocks do not follow k");
    bus_clash_a: assert property (!(ctl_dq_oe && dev_dq_oe))
        else $error("both ends drive the data pins");
    // the extra idle tick lets a previous write finish driving
    write_drive_a: assert property (wr_start_s |->
        ##1 !ctl_dq_oe[*3] ##1 ctl_dq_oe[*5] ##1 !ctl_dq_oe)
        else $error("write data not driven in its two word slots");
    read_release_a: assert property (rd_start_s |-> ##1 !ctl_dq_oe[*7])
        else $error("controller drives the bus during a read");
    read_off_lat_a: assert property ((rd_start_s and dll_disable_pin) |->
        !dev_dq_oe[*6] ##1 dev_dq_oe[*4] ##1 !dev_dq_oe)
        else $error("read words misplaced with dll off");
    read_on_lat_a: assert property ((rd_start_s and !dll_disable_pin) |->
        !dev_dq_oe[*8] ##1 dev_dq_oe[*4] ##1 !dev_dq_oe)
        else $error("read words misplaced with dll on");

    // main traffic kinds
    cover property (wr_start_s);
    cover property (rd_start_s and dll_disable_pin);
    cover property (rd_start_s and !dll_disable_pin);
endmodule : dtwbsp_link_monitor
`default_nettype wire

// ==== ddr_two_word_burst_sram_port_test.sv ====
// self-checking bench joining controller and sram across the link
`timescale 1ns/1ps
`default_nettype none
module ddr_two_word_burst_sram_port_test import dtwbsp_pkg::*;;
    localparam int AW = 8;
    localparam int WW = 18;
    localparam int LN = 2;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic ce = 1'b1;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic [AW-1:0] req_addr = '0;
    logic [WW-1:0] req_wdata0 = '0;
    logic [WW-1:0] req_wdata1 = '0;
    logic [LN-1:0] req_be_n0 = '1;
    logic [LN-1:0] req_be_n1 = '1;
    logic dll_off = 1'b1;
    logic req_ready;
    logic rsp_valid;
    logic [WW-1:0] rsp_data0;
    logic [WW-1:0] rsp_data1;
    logic dll_off_status;
    logic write_commit;
    int mismatches = 0;
    int checks = 0;
    int cycles = 0;
    time take_t = 0;

    // ------------------------------------------------------------------
    // clock, ends and checker
    // ------------------------------------------------------------------
    always #2 clk = ~clk;

    dtwbsp_link_if #(.ADDR_W(AW), .WORD_W(WW), .LANES(LN)) i_dtwbsp_link_if ();
    dtwbsp_ctrl #(.ADDR_W(AW), .WORD_W(WW), .LANES(LN)) i_dtwbsp_ctrl (
        .clk(clk), .rst_b(rst_b), .ce(ce), .req_valid(req_valid),
        .req_write(req_write), .req_addr(req_addr), .req_wdata0(req_wdata0),
        .req_wdata1(req_wdata1), .req_be_n0(req_be_n0), .req_be_n1(req_be_n1),
        .dll_off(dll_off), .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp_data0(rsp_data0), .rsp_data1(rsp_data1), .link(i_dtwbsp_link_if.ctl));
    dtwbsp_device #(.ADDR_W(AW), .WORD_W(WW), .LANES(LN)) i_dtwbsp_device (
        .rst_b(rst_b), .ce(ce), .link(i_dtwbsp_link_if.dev),
        .dll_off_status(dll_off_status), .write_commit(write_commit));
    dtwbsp_link_monitor i_dtwbsp_link_monitor (
        .clk(clk), .rst_b(rst_b), .k(i_dtwbsp_link_if.k), .k_n(i_dtwbsp_link_if.k_n),
        .load_strobe_n(i_dtwbsp_link_if.load_strobe_n),
        .read_write_sel(i_dtwbsp_link_if.read_write_sel),
        .dll_disable_pin(i_dtwbsp_link_if.dll_disable_pin),
        .ctl_dq_oe(i_dtwbsp_link_if.ctl_dq_oe), .dev_dq_oe(i_dtwbsp_link_if.dev_dq_oe),
        .echo_clk_out(i_dtwbsp_link_if.echo_clk_out),
        .echo_clk_out_n(i_dtwbsp_link_if.echo_clk_out_n));

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // one request; exp_lat 0 returns at once so the next can follow at full rate
    task automatic do_op(input logic wr, input logic [AW-1:0] a, input logic [WW-1:0] d0,
        input logic [WW-1:0] d1, input logic [LN-1:0] b0, input logic [LN-1:0] b1,
        input int exp_lat);
        int n;
        logic seen_lo;
        @(posedge clk);
        #1;
        req_valid = 1'b1;
        req_write = wr;
        req_addr = a;
        req_wdata0 = d0;
        req_wdata1 = d1;
        req_be_n0 = b0;
        req_be_n1 = b1;
        // ready is read once settled; it speaks for the coming edge
        while (req_ready !== 1'b1) begin
            @(posedge clk);
            #1;
        end
        @(posedge clk);
        take_t = $time;
        #1;
        req_valid = 1'b0;
        check("ready after take", 32'(req_ready), 32'h0);
        n = 0;
        seen_lo = 1'b0;
        // the commit flag of the write before may still stand
        while (exp_lat != 0 && n < 40 &&
            !(seen_lo && (wr ? write_commit : rsp_valid) === 1'b1)) begin
            if ((wr ? write_commit : rsp_valid) === 1'b0) begin
                seen_lo = 1'b1;
            end
            @(posedge clk);
            #1;
            n++;
        end
        if (exp_lat != 0) check("done tick", 32'(n), 32'(exp_lat));
    endtask : do_op

    task automatic check_rd(input logic [WW-1:0] e0, input logic [WW-1:0] e1);
        check("read word0", 32'(rsp_data0), 32'(e0));
        check("read word1", 32'(rsp_data1), 32'(e1));
    endtask : check_rd

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    // burst start taken from the address lsb, both directions
    task automatic t_burst_order();
        do_op(1'b1, 8'h04, 18'h0a5a5, 18'h15a5a, 2'b00, 2'b00, 6);
        do_op(1'b1, 8'h07, 18'h11111, 18'h22222, 2'b00, 2'b00, 6);
        do_op(1'b0, 8'h04, '0, '0, '1, '1, 11);
        check_rd(18'h0a5a5, 18'h15a5a);
        do_op(1'b0, 8'h05, '0, '0, '1, '1, 11);
        check_rd(18'h15a5a, 18'h0a5a5);
        do_op(1'b0, 8'h06, '0, '0, '1, '1, 11);
        check_rd(18'h22222, 18'h11111);
        check("mode status", 32'(dll_off_status), 32'h1);
    endtask : t_burst_order

    // lane selects are taken separately with each word
    task automatic t_lanes();
        do_op(1'b1, 8'h04, 18'h3ffff, 18'h3ffff, 2'b10, 2'b01, 6);
        do_op(1'b0, 8'h04, '0, '0, '1, '1, 11);
        check_rd(18'h0a5ff, 18'h3fe5a);
    endtask : t_lanes

    // half-cycle-later read with the dll on, then back to dll off
    task automatic t_dll_on();
        @(posedge clk);
        #1;
        dll_off = 1'b0;
        repeat (20) @(posedge clk);
        check("mode status", 32'(dll_off_status), 32'h0);
        do_op(1'b0, 8'h06, '0, '0, '1, '1, 13);
        check_rd(18'h22222, 18'h11111);
        @(posedge clk);
        #1;
        dll_off = 1'b1;
        repeat (20) @(posedge clk);
    endtask : t_dll_on

    // full-rate writes then full-rate reads, spacing measured at the takes
    task automatic t_back_to_back();
        time t1;
        do_op(1'b1, 8'h10, 18'h00001, 18'h00002, 2'b00, 2'b00, 0);
        t1 = take_t;
        do_op(1'b1, 8'h12, 18'h00003, 18'h00004, 2'b00, 2'b00, 6);
        check("write spacing", 32'((take_t - t1) / 4), 32'h8);
        do_op(1'b0, 8'h10, '0, '0, '1, '1, 11);
        t1 = take_t;
        check_rd(18'h00001, 18'h00002);
        do_op(1'b0, 8'h13, '0, '0, '1, '1, 11);
        check("read spacing", 32'((take_t - t1) / 4), 32'h10);
        check_rd(18'h00004, 18'h00003);
    endtask : t_back_to_back

    // ------------------------------------------------------------------
    // run control
    // ------------------------------------------------------------------
    task automatic final_report();
        if (mismatches == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report

    // the whole sequence needs well under a thousand ticks
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            final_report();
        end
    end

    // both ends share one asynchronous reset, released off the edge
    initial begin
        repeat (2) @(posedge clk);
        #1;
        rst_b = 1'b1;
        t_burst_order();
        t_lanes();
        t_dll_on();
        t_back_to_back();
        final_report();
    end
endmodule : ddr_two_word_burst_sram_port_test
`default_nettype wire
